// ### core/iors_io_space.sv
`timescale 1ns/1ps
`default_nettype none

module iors_io_space
  import iors_pkg::*;
#(
  parameter int RESUME_LONG  = RESUME_LONG_CYC,
  parameter int RESUME_SHORT = RESUME_SHORT_CYC,
  parameter int WAKE_DELAY   = WAKE_INT_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic       port_read_instr,
  input  wire logic       port_write_instr,
  input  wire logic       indexed_port_write_instr,
  input  wire logic [7:0] instr_addr,
  input  wire logic [7:0] x_index,
  input  wire logic [7:0] acc_in,
  output logic      [7:0] rd_data,
  input  wire logic       usb_dplus_pin,
  input  wire logic       usb_dminus_pin,
  input  wire logic       regulator_pin,
  input  wire logic       osc_input_pin,
  input  wire logic       capt_a_pin,
  input  wire logic       capt_b_pin,
  input  wire logic       suspend_wake,
  input  wire logic [7:0] proc_status_set,
  output logic            cpu_halt,
  output logic            ext_osc_active,
  output logic      [7:0] port0_out,
  output logic      [7:0] port1_out,
  output logic      [7:0] port0_irq_en,
  output logic      [7:0] port1_irq_en,
  output logic      [7:0] port0_irq_pol,
  output logic      [7:0] port1_irq_pol,
  output logic      [15:0] port0_drive_cfg,
  output logic      [15:0] port1_drive_cfg,
  output logic      [7:0] clock_config,
  output logic            watchdog_reset
);

  initial begin
    if (RESUME_LONG < 1 || RESUME_SHORT < 1 || WAKE_DELAY < 1 || RESUME_LONG >= (1 << 16) ||
        RESUME_SHORT > RESUME_LONG || WAKE_DELAY > RESUME_LONG)
      $error("iors_io_space: resume delay parameters out of range");
  end

  // ------------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------------
  logic [7:0] wr_addr;
  logic       wr_en;

  // Indexed form adds X; zero field leaves X alone, wrapping mod 256
  assign wr_addr = indexed_port_write_instr ? 8'(x_index + instr_addr) : instr_addr;
  assign wr_en   = clk_en && (port_write_instr || indexed_port_write_instr);

  function automatic logic hit(input logic [7:0] target);
    hit = wr_en && (wr_addr == target);
  endfunction : hit

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [5:0] pin_meta_ff;
  logic [5:0] pin_sync_ff;

  // Two stages; only the second stage is seen by logic
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_meta_ff <= 6'h00;
      pin_sync_ff <= 6'h00;
    end else if (clk_en) begin
      pin_meta_ff <= {capt_b_pin, capt_a_pin, usb_dplus_pin, regulator_pin,
                      osc_input_pin, usb_dminus_pin};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ------------------------------------------------------------------
  // Plain read/write and write-only registers
  // ------------------------------------------------------------------
  logic [7:0] rw_ff [0:15];
  logic [3:0] rw_idx;
  logic       rw_hit;

  // Sixteen-entry bank for the simple storage registers
  always_comb begin
    rw_hit = 1'b1;
    rw_idx = 4'h0;
    case (wr_addr)
      ADDR_PORT0_DATA:    rw_idx = 4'h0;
      ADDR_PORT1_DATA:    rw_idx = 4'h1;
      ADDR_USB_ADDR:      rw_idx = 4'h2;
      ADDR_EP0_COUNT:     rw_idx = 4'h3;
      ADDR_EP0_CFG:       rw_idx = 4'h4;
      ADDR_EP1_COUNT:     rw_idx = 4'h5;
      ADDR_EP1_CFG:       rw_idx = 4'h6;
      ADDR_EP2_COUNT:     rw_idx = 4'h7;
      ADDR_EP2_CFG:       rw_idx = 4'h8;
      ADDR_USB_STAT_CTL:  rw_idx = 4'h9;
      ADDR_GLOBAL_IRQ_EN: rw_idx = 4'ha;
      ADDR_EP_IRQ_EN:     rw_idx = 4'hb;
      ADDR_CAPT_CONFIG:   rw_idx = 4'hc;
      ADDR_SERIAL_DATA:   rw_idx = 4'hd;
      ADDR_SERIAL_CTRL:   rw_idx = 4'he;
      default:            rw_hit = 1'b0;
    endcase
  end

  // Read-only and unassigned addresses fall through untouched
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 16; i++) begin
        rw_ff[i] <= RST_ZERO;
      end
    end else if (wr_en && rw_hit) begin
      rw_ff[rw_idx] <= acc_in;
    end
  end

  logic [7:0] p0_ien_ff, p1_ien_ff, p0_pol_ff, p1_pol_ff;
  logic [7:0] p0_drv_a_ff, p0_drv_b_ff, p1_drv_a_ff, p1_drv_b_ff;

  // Write-only pin control registers; never placed on the read path
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      p0_ien_ff   <= RST_ZERO;
      p1_ien_ff   <= RST_ZERO;
      p0_pol_ff   <= RST_ZERO;
      p1_pol_ff   <= RST_ZERO;
      p0_drv_a_ff <= RST_ZERO;
      p0_drv_b_ff <= RST_ZERO;
      p1_drv_a_ff <= RST_ZERO;
      p1_drv_b_ff <= RST_ZERO;
    end else begin
      if (hit(ADDR_P0_IRQ_EN))  p0_ien_ff   <= acc_in;
      if (hit(ADDR_P1_IRQ_EN))  p1_ien_ff   <= acc_in;
      if (hit(ADDR_P0_IRQ_POL)) p0_pol_ff   <= acc_in;
      if (hit(ADDR_P1_IRQ_POL)) p1_pol_ff   <= acc_in;
      if (hit(ADDR_P0_DRV_A))   p0_drv_a_ff <= acc_in;
      if (hit(ADDR_P0_DRV_B))   p0_drv_b_ff <= acc_in;
      if (hit(ADDR_P1_DRV_A))   p1_drv_a_ff <= acc_in;
      if (hit(ADDR_P1_DRV_B))   p1_drv_b_ff <= acc_in;
    end
  end

  // Watchdog kick is a strobe; the data value is irrelevant
  logic wdog_kick_ff;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wdog_kick_ff <= 1'b0;
    end else if (clk_en) begin
      wdog_kick_ff <= hit(ADDR_WDOG_KICK);
    end
  end

  // ------------------------------------------------------------------
  // Free-running timer and captures
  // ------------------------------------------------------------------
  logic [3:0]  tick_div_ff;
  logic [11:0] free_timer_ff;
  logic        tick;

  assign tick = (tick_div_ff == 4'(TICK_DIV - 1));

  // Prescale 10 MHz down to the 1 MHz timer tick
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tick_div_ff   <= 4'h0;
      free_timer_ff <= 12'h000;
    end else if (clk_en) begin
      tick_div_ff <= tick ? 4'h0 : tick_div_ff + 4'h1;
      if (tick) free_timer_ff <= free_timer_ff + 12'h001;
    end
  end

  logic [1:0] capt_prev_ff;
  logic [7:0] capt_ff [0:3];
  logic [7:0] capt_stat_ff;

  // Edge captures of the timer low byte, read-only to software
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      capt_prev_ff <= 2'b00;
      capt_stat_ff <= RST_ZERO;
      for (int i = 0; i < 4; i++) begin
        capt_ff[i] <= RST_ZERO;
      end
    end else if (clk_en) begin
      capt_prev_ff <= pin_sync_ff[5:4];
      for (int c = 0; c < 2; c++) begin
        if (pin_sync_ff[4+c] && !capt_prev_ff[c]) begin
          capt_ff[2*c]       <= free_timer_ff[7:0];
          capt_stat_ff[2*c]  <= 1'b1;
        end
        if (!pin_sync_ff[4+c] && capt_prev_ff[c]) begin
          capt_ff[2*c+1]      <= free_timer_ff[7:0];
          capt_stat_ff[2*c+1] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Clock configuration and processor status
  // ------------------------------------------------------------------
  logic [7:0] clk_cfg_ff;
  logic [7:0] proc_stat_ff;

  // Whole byte is storage; software writes reserved bits as zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      clk_cfg_ff   <= RST_CLOCK_CONFIG;
      proc_stat_ff <= RST_PROC_STAT_CTL;
    end else begin
      if (hit(ADDR_CLOCK_CONFIG)) clk_cfg_ff <= acc_in;
      if (hit(ADDR_PROC_STAT_CTL)) begin
        proc_stat_ff <= acc_in | proc_status_set;
      end else if (clk_en) begin
        proc_stat_ff <= proc_stat_ff | proc_status_set;
      end
    end
  end

  // ------------------------------------------------------------------
  // Oscillator switch and resume delay
  // ------------------------------------------------------------------
  iors_clk_state_type clk_state_ff;
  logic [15:0]        delay_ff;
  logic               ext_start;

  // Only a write with the enable bit set, taken in the internal state, triggers the switch
  assign ext_start = hit(ADDR_CLOCK_CONFIG) && acc_in[CLK_EXT_OSC_BIT] &&
                     (clk_state_ff == IORS_CK_INTERNAL);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      clk_state_ff <= IORS_CK_INTERNAL;
      delay_ff     <= 16'h0000;
    end else if (clk_en) begin
      case (clk_state_ff)
        IORS_CK_INTERNAL: begin
          if (ext_start) begin
            clk_state_ff <= IORS_CK_HALT;
            delay_ff <= acc_in[CLK_RESUME_DELAY_BIT] ? 16'(RESUME_LONG - 1)
                                                     : 16'(RESUME_SHORT - 1);
          end
        end
        IORS_CK_HALT: begin
          if (delay_ff == 16'h0000) begin
            // Bit 0 low means an internal-oscillator wake
            clk_state_ff <= clk_cfg_ff[CLK_EXT_OSC_BIT] ? IORS_CK_EXTERNAL
                                                        : IORS_CK_INTERNAL;
          end else begin
            delay_ff <= delay_ff - 16'h0001;
          end
        end
        IORS_CK_EXTERNAL: begin
          // Clearing the enable bit alone changes nothing here
          if (suspend_wake) begin
            clk_state_ff <= IORS_CK_HALT;
            if (clk_cfg_ff[CLK_EXT_OSC_BIT]) begin
              delay_ff <= clk_cfg_ff[CLK_RESUME_DELAY_BIT] ? 16'(RESUME_LONG - 1)
                                                           : 16'(RESUME_SHORT - 1);
            end else begin
              delay_ff <= 16'(WAKE_DELAY - 1);
            end
          end
        end
        default: clk_state_ff <= IORS_CK_INTERNAL;
      endcase
    end
  end

  // Internal-mode wake on suspend still stalls: WAKE_DELAY with bit 0 clear, else the resume delay
  logic wake_int_ff;
  logic [15:0] wake_cnt_ff;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wake_int_ff <= 1'b0;
      wake_cnt_ff <= 16'h0000;
    end else if (clk_en) begin
      if (suspend_wake && clk_state_ff == IORS_CK_INTERNAL) begin
        wake_int_ff <= 1'b1;
        wake_cnt_ff <= clk_cfg_ff[CLK_EXT_OSC_BIT] ?
                       (clk_cfg_ff[CLK_RESUME_DELAY_BIT] ? 16'(RESUME_LONG - 1)
                                                         : 16'(RESUME_SHORT - 1))
                       : 16'(WAKE_DELAY - 1);
      end else if (wake_cnt_ff != 16'h0000) begin
        wake_cnt_ff <= wake_cnt_ff - 16'h0001;
      end else begin
        wake_int_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  logic [7:0] nxt_rd_data;
  logic [7:0] rd_data_ff;
  logic [7:0] aux_byte;

  assign aux_byte = {4'h0, pin_sync_ff[3], pin_sync_ff[2], pin_sync_ff[1],
                     pin_sync_ff[0]};

  // Write-only and unassigned addresses answer zero
  always_comb begin
    case (instr_addr)
      ADDR_PORT0_DATA:    nxt_rd_data = rw_ff[0];
      ADDR_PORT1_DATA:    nxt_rd_data = rw_ff[1];
      ADDR_AUX_INPUT:     nxt_rd_data = aux_byte;
      ADDR_USB_ADDR:      nxt_rd_data = rw_ff[2];
      ADDR_EP0_COUNT:     nxt_rd_data = rw_ff[3];
      ADDR_EP0_CFG:       nxt_rd_data = rw_ff[4];
      ADDR_EP1_COUNT:     nxt_rd_data = rw_ff[5];
      ADDR_EP1_CFG:       nxt_rd_data = rw_ff[6];
      ADDR_EP2_COUNT:     nxt_rd_data = rw_ff[7];
      ADDR_EP2_CFG:       nxt_rd_data = rw_ff[8];
      ADDR_USB_STAT_CTL:  nxt_rd_data = rw_ff[9];
      ADDR_GLOBAL_IRQ_EN: nxt_rd_data = rw_ff[10];
      ADDR_EP_IRQ_EN:     nxt_rd_data = rw_ff[11];
      ADDR_TIMER_LOW:     nxt_rd_data = free_timer_ff[7:0];
      ADDR_TIMER_HIGH:    nxt_rd_data = {4'h0, free_timer_ff[11:8]};
      ADDR_CAPT_A_RISE:   nxt_rd_data = capt_ff[0];
      ADDR_CAPT_A_FALL:   nxt_rd_data = capt_ff[1];
      ADDR_CAPT_B_RISE:   nxt_rd_data = capt_ff[2];
      ADDR_CAPT_B_FALL:   nxt_rd_data = capt_ff[3];
      ADDR_CAPT_CONFIG:   nxt_rd_data = rw_ff[12];
      ADDR_CAPT_STATUS:   nxt_rd_data = capt_stat_ff;
      ADDR_SERIAL_DATA:   nxt_rd_data = rw_ff[13];
      ADDR_SERIAL_CTRL:   nxt_rd_data = rw_ff[14];
      ADDR_CLOCK_CONFIG:  nxt_rd_data = clk_cfg_ff;
      ADDR_PROC_STAT_CTL: nxt_rd_data = proc_stat_ff;
      default:            nxt_rd_data = RST_ZERO;
    endcase
  end

  // Registered answer, one cycle after the read request
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rd_data_ff <= RST_ZERO;
    end else if (clk_en && port_read_instr) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign rd_data         = rd_data_ff;
  assign cpu_halt        = (clk_state_ff == IORS_CK_HALT) || wake_int_ff;
  assign ext_osc_active  = (clk_state_ff != IORS_CK_INTERNAL);
  assign port0_out       = rw_ff[0];
  assign port1_out       = rw_ff[1];
  assign port0_irq_en    = p0_ien_ff;
  assign port1_irq_en    = p1_ien_ff;
  assign port0_irq_pol   = p0_pol_ff;
  assign port1_irq_pol   = p1_pol_ff;
  assign port0_drive_cfg = {p0_drv_b_ff, p0_drv_a_ff};
  assign port1_drive_cfg = {p1_drv_b_ff, p1_drv_a_ff};
  assign clock_config    = clk_cfg_ff;
  assign watchdog_reset  = wdog_kick_ff;

endmodule : iors_io_space
`default_nettype wire

// ### core/iors_pkg.sv
package iors_pkg;

  // ------------------------------------------------------------------
  // Port addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT0_DATA    = 8'h00;
  localparam logic [7:0] ADDR_PORT1_DATA    = 8'h01;
  localparam logic [7:0] ADDR_AUX_INPUT     = 8'h02;
  localparam logic [7:0] ADDR_P0_IRQ_EN     = 8'h04;
  localparam logic [7:0] ADDR_P1_IRQ_EN     = 8'h05;
  localparam logic [7:0] ADDR_P0_IRQ_POL    = 8'h06;
  localparam logic [7:0] ADDR_P1_IRQ_POL    = 8'h07;
  localparam logic [7:0] ADDR_P0_DRV_A      = 8'h0a;
  localparam logic [7:0] ADDR_P0_DRV_B      = 8'h0b;
  localparam logic [7:0] ADDR_P1_DRV_A      = 8'h0c;
  localparam logic [7:0] ADDR_P1_DRV_B      = 8'h0d;
  localparam logic [7:0] ADDR_USB_ADDR      = 8'h10;
  localparam logic [7:0] ADDR_EP0_COUNT     = 8'h11;
  localparam logic [7:0] ADDR_EP0_CFG       = 8'h12;
  localparam logic [7:0] ADDR_EP1_COUNT     = 8'h13;
  localparam logic [7:0] ADDR_EP1_CFG       = 8'h14;
  localparam logic [7:0] ADDR_EP2_COUNT     = 8'h15;
  localparam logic [7:0] ADDR_EP2_CFG       = 8'h16;
  localparam logic [7:0] ADDR_USB_STAT_CTL  = 8'h1f;
  localparam logic [7:0] ADDR_GLOBAL_IRQ_EN = 8'h20;
  localparam logic [7:0] ADDR_EP_IRQ_EN     = 8'h21;
  localparam logic [7:0] ADDR_TIMER_LOW     = 8'h24;
  localparam logic [7:0] ADDR_TIMER_HIGH    = 8'h25;
  localparam logic [7:0] ADDR_WDOG_KICK     = 8'h26;
  localparam logic [7:0] ADDR_CAPT_A_RISE   = 8'h40;
  localparam logic [7:0] ADDR_CAPT_A_FALL   = 8'h41;
  localparam logic [7:0] ADDR_CAPT_B_RISE   = 8'h42;
  localparam logic [7:0] ADDR_CAPT_B_FALL   = 8'h43;
  localparam logic [7:0] ADDR_CAPT_CONFIG   = 8'h44;
  localparam logic [7:0] ADDR_CAPT_STATUS   = 8'h45;
  localparam logic [7:0] ADDR_SERIAL_DATA   = 8'h60;
  localparam logic [7:0] ADDR_SERIAL_CTRL   = 8'h61;
  localparam logic [7:0] ADDR_CLOCK_CONFIG  = 8'hf8;
  localparam logic [7:0] ADDR_PROC_STAT_CTL = 8'hff;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_ZERO           = 8'h00;
  localparam logic [7:0] RST_CLOCK_CONFIG   = 8'h00;
  localparam logic [7:0] RST_PROC_STAT_CTL  = 8'h01;

  // ------------------------------------------------------------------
  // Clock configuration fields
  // ------------------------------------------------------------------
  localparam int CLK_RESUME_DELAY_BIT = 7;
  localparam int CLK_WAKE_ADJ_MSB     = 6;
  localparam int CLK_WAKE_ADJ_LSB     = 4;
  localparam int CLK_EXT_OSC_BIT      = 0;

  // Auxiliary input bit positions
  localparam int AUX_DMINUS_BIT = 0;
  localparam int AUX_OSC_IN_BIT = 1;
  localparam int AUX_REG_BIT    = 2;
  localparam int AUX_DPLUS_BIT  = 3;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int TIMER_TICK_HZ   = 1_000_000;
  localparam int TICK_DIV        = CLK_HZ / TIMER_TICK_HZ;
  localparam int RESUME_LONG_US  = 4000;
  localparam int RESUME_SHORT_US = 128;
  localparam int WAKE_INT_US     = 8;
  localparam int OSC_START_US    = 1;
  localparam int RESUME_LONG_CYC  = RESUME_LONG_US * (CLK_HZ / 1_000_000);
  localparam int RESUME_SHORT_CYC = RESUME_SHORT_US * (CLK_HZ / 1_000_000);
  localparam int WAKE_INT_CYC     = (WAKE_INT_US + OSC_START_US) * (CLK_HZ / 1_000_000);

  // Clock control states
  typedef enum logic [1:0] {
    IORS_CK_INTERNAL = 2'b00,
    IORS_CK_HALT     = 2'b01,
    IORS_CK_EXTERNAL = 2'b10
  } iors_clk_state_type;

endpackage : iors_pkg

// ### bench/iors_io_space_properties.sv
`timescale 1ns/1ps
`default_nettype none

module iors_io_space_properties #(
  parameter int RESUME_LONG  = 20,
  parameter int RESUME_SHORT = 10,
  parameter int WAKE_DELAY   = 5
) (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       clk_en,
  input wire logic       port_read_instr,
  input wire logic       port_write_instr,
  input wire logic       indexed_port_write_instr,
  input wire logic [7:0] instr_addr,
  input wire logic [7:0] x_index,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] rd_data,
  input wire logic       suspend_wake,
  input wire logic       cpu_halt,
  input wire logic       ext_osc_active,
  input wire logic [7:0] port0_out,
  input wire logic [7:0] clock_config
);
  // ------------------------------------------------------------
  // Decoded requests and halt length
  // ------------------------------------------------------------
  logic [7:0]  idx_addr;
  logic        rd_cfg, rd_wo, wr_cfg, wr_p0;
  logic [15:0] halt_len_ff;

  // Indexed target wraps at 256
  assign idx_addr = 8'(x_index + instr_addr);
  assign rd_cfg = clk_en && port_read_instr && instr_addr == 8'hf8;
  assign rd_wo = clk_en && port_read_instr &&
                 instr_addr inside {[8'h04:8'h07], [8'h0a:8'h0d]};
  assign wr_cfg = clk_en && (port_write_instr && instr_addr == 8'hf8 ||
                  indexed_port_write_instr && idx_addr == 8'hf8);
  assign wr_p0 = clk_en && (port_write_instr && instr_addr == 8'h00 ||
                 indexed_port_write_instr && idx_addr == 8'h00);

  // Halted cycles, frozen while the enable is low
  always_ff @(posedge sys_clk) begin
    if (!rst_b) halt_len_ff <= 16'h0000;
    else if (clk_en) halt_len_ff <= cpu_halt ? halt_len_ff + 16'h0001 : 16'h0000;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  read_clock_cfg_a: assert property (rd_cfg |=> rd_data == $past(clock_config))
    else $error("clock config read wrong");
  read_wo_zero_a: assert property (rd_wo |=> rd_data == 8'h00)
    else $error("write-only read not zero");
  write_clock_cfg_a: assert property (wr_cfg |=> clock_config == $past(acc_in))
    else $error("clock config write lost");
  write_port0_a: assert property (wr_p0 |=> port0_out == $past(acc_in))
    else $error("port0 write lost");
  port0_hold_a: assert property (!wr_p0 |=> $stable(port0_out))
    else $error("port0 changed without write");
  halt_start_a: assert property (wr_cfg && acc_in[0] && !ext_osc_active
    |=> cpu_halt && ext_osc_active)
    else $error("external switch did not halt");
  clear_no_effect_a: assert property (wr_cfg && !acc_in[0] && ext_osc_active && !cpu_halt
    && !suspend_wake |=> ext_osc_active && !cpu_halt)
    else $error("clearing external enable acted");
  halt_long_a: assert property ($fell(cpu_halt) && ext_osc_active && clock_config[7]
    |-> halt_len_ff == RESUME_LONG)
    else $error("long resume delay wrong");
  halt_short_a: assert property ($fell(cpu_halt) && ext_osc_active && !clock_config[7]
    |-> halt_len_ff == RESUME_SHORT)
    else $error("short resume delay wrong");
  wake_internal_a: assert property ($fell(cpu_halt) && !ext_osc_active
    |-> halt_len_ff == WAKE_DELAY)
    else $error("internal wake delay wrong");

  cover property (wr_cfg && acc_in[0]);
  cover property ($fell(cpu_halt) && !ext_osc_active);
  cover property (rd_cfg);
endmodule : iors_io_space_properties

bind iors_io_space iors_io_space_properties #(.RESUME_LONG(RESUME_LONG),
  .RESUME_SHORT(RESUME_SHORT), .WAKE_DELAY(WAKE_DELAY)) i_iors_io_space_properties (
  .sys_clk, .rst_b, .clk_en, .port_read_instr, .port_write_instr, .indexed_port_write_instr,
  .instr_addr, .x_index, .acc_in, .rd_data, .suspend_wake, .cpu_halt, .ext_osc_active,
  .port0_out, .clock_config);

`default_nettype wire

// ### bench/iors_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module iors_cpu_model (
  input  wire logic       sys_clk,
  output logic            port_read_instr,
  output logic            port_write_instr,
  output logic            indexed_port_write_instr,
  output logic      [7:0] instr_addr,
  output logic      [7:0] x_index,
  output logic      [7:0] acc_in
);
  // ------------------------------------------------------------
  // Core issuing port instructions
  // ------------------------------------------------------------
  initial begin
    {port_read_instr, port_write_instr, indexed_port_write_instr, instr_addr, x_index,
     acc_in} = 27'h0000000;
  end

  // Kind is {read, write, indexed}; never a reserved address
  task automatic issue(input logic [2:0] k, input logic [7:0] a, input logic [7:0] x,
                       input logic [7:0] d);
    @(negedge sys_clk);
    {port_read_instr, port_write_instr, indexed_port_write_instr} = k;
    {instr_addr, x_index, acc_in} = {a, x, d};
    @(negedge sys_clk);
    {port_read_instr, port_write_instr, indexed_port_write_instr} = 3'b000;
    {instr_addr, x_index, acc_in} = ~{a, x, d}; // Stale operands must never look valid
  endtask : issue
endmodule : iors_cpu_model

`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import iors_pkg::*;
;
  localparam int LONG_C = 20;
  localparam int SHORT_C = 10;
  localparam int WAKE_C = 5;
  localparam logic [7:0] RW_A [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h20, 8'h21, 8'h44};
  localparam logic [7:0] WO_A [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
  logic        sys_clk = 1'b0;
  logic        rst_b, clk_en, suspend_wake, cpu_halt, ext_osc_active, watchdog_reset;
  logic        port_read_instr, port_write_instr, indexed_port_write_instr, rd_pend_ff;
  logic        usb_dplus_pin, usb_dminus_pin, regulator_pin, osc_input_pin;
  logic        capt_a_pin = 1'b0;
  logic        capt_b_pin = 1'b0;
  logic [7:0]  proc_status_set = 8'h00;
  logic [7:0]  instr_addr, x_index, acc_in, rd_data, clock_config, last_rd, d;
  logic [7:0]  port0_out, port1_out, port0_irq_en, port1_irq_en, port0_irq_pol, port1_irq_pol;
  logic [15:0] port0_drive_cfg, port1_drive_cfg;
  logic [15:0] exp_q [$];
  logic [63:0] wo_all;
  integer      seed = 32'h37a3;
  int          error_cnt = 0;
  int          num_checks = 0;

  // Write-only outputs in address order
  assign wo_all = {port1_drive_cfg, port0_drive_cfg, port1_irq_pol, port0_irq_pol,
                   port1_irq_en, port0_irq_en};

  always #50 sys_clk = ~sys_clk;

  iors_io_space #(.RESUME_LONG(LONG_C), .RESUME_SHORT(SHORT_C), .WAKE_DELAY(WAKE_C))
    i_iors_io_space (.sys_clk, .rst_b, .clk_en, .port_read_instr, .port_write_instr,
    .indexed_port_write_instr, .instr_addr, .x_index, .acc_in, .rd_data, .usb_dplus_pin,
    .usb_dminus_pin, .regulator_pin, .osc_input_pin, .capt_a_pin, .capt_b_pin,
    .suspend_wake, .proc_status_set, .cpu_halt, .ext_osc_active, .port0_out, .port1_out,
    .port0_irq_en, .port1_irq_en, .port0_irq_pol, .port1_irq_pol, .port0_drive_cfg,
    .port1_drive_cfg, .clock_config, .watchdog_reset);

  iors_cpu_model i_iors_cpu_model (.sys_clk, .port_read_instr, .port_write_instr,
    .indexed_port_write_instr, .instr_addr, .x_index, .acc_in);

  // ------------------------------------------------------------
  // Compare, read, halt and closing tasks
  // ------------------------------------------------------------
  task automatic chk8(input logic [7:0] a, input logic [7:0] e);
    num_checks++;
    if (a !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : chk8

  task automatic io(input logic [2:0] k, input logic [7:0] a, x, d);
    i_iors_cpu_model.issue(k, a, x, d);
  endtask : io

  // Note the expectation, then read
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    io(3'b100, a, 8'h00, 8'h00);
  endtask : rd_exp

  // Bounded count of halted cycles at falling edges
  task automatic halt_chk(input int n);
    int c = 0;
    while (cpu_halt === 1'b1 && c < 1000) begin
      c++;
      @(negedge sys_clk);
    end
    chk8(8'(c), 8'(n));
  endtask : halt_chk

  task automatic do_reset();
    rst_b = 1'b0;
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
  endtask : do_reset

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // Read answer lands at the taking edge; checked at the next falling edge
  always @(posedge sys_clk) rd_pend_ff <= port_read_instr & clk_en & rst_b;
  always @(negedge sys_clk) begin
    if (rd_pend_ff === 1'b1) begin
      last_rd <= rd_data;
      chk8(rd_data & exp_q[0][15:8], exp_q[0][7:0] & exp_q[0][15:8]);
      void'(exp_q.pop_front());
    end
  end

  // Watchdog: the run needs under a thousand cycles
  initial begin
    repeat (4000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    clk_en = 1'b1;
    suspend_wake = 1'b0;
    {usb_dplus_pin, regulator_pin, osc_input_pin, usb_dminus_pin} = 4'h0;
    do_reset();
    rd_exp(ADDR_CLOCK_CONFIG, 8'h00, 8'hff);
    rd_exp(ADDR_PROC_STAT_CTL, RST_PROC_STAT_CTL, 8'hff);
    foreach (RW_A[i]) rd_exp(RW_A[i], 8'h00, 8'hff);
    foreach (RW_A[i]) begin
      d = 8'($random(seed));
      io(3'b010, RW_A[i], 8'h00, d);
      rd_exp(RW_A[i], d, 8'hff);
    end
    foreach (WO_A[i]) begin
      d = 8'($random(seed));
      io(3'b010, WO_A[i], 8'h00, d);
      chk8(wo_all[8*i +: 8], d);
      rd_exp(WO_A[i], 8'h00, 8'hff);
    end
    io(3'b001, 8'h01, 8'h03, 8'h3c);
    chk8(port0_irq_en, 8'h3c);
    io(3'b001, 8'h02, 8'hff, 8'hc3);
    chk8(port1_out, 8'hc3);
    io(3'b001, 8'h00, 8'h0d, 8'h96);
    chk8(port1_drive_cfg[15:8], 8'h96);
    io(3'b010, ADDR_CAPT_A_RISE, 8'h00, 8'hff);
    rd_exp(ADDR_CAPT_A_RISE, 8'h00, 8'hff);
    io(3'b010, ADDR_TIMER_HIGH, 8'h00, 8'hff);
    rd_exp(ADDR_TIMER_HIGH, 8'h00, 8'hf0);
    // Enable low must swallow the write
    io(3'b010, ADDR_PORT0_DATA, 8'h00, 8'h5a);
    clk_en = 1'b0;
    io(3'b010, ADDR_PORT0_DATA, 8'h00, 8'ha5);
    clk_en = 1'b1;
    chk8(port0_out, 8'h5a);
    // Reads taken 100 cycles apart see ten timer ticks
    rd_exp(ADDR_TIMER_LOW, 8'h00, 8'h00);
    repeat (98) @(negedge sys_clk);
    rd_exp(ADDR_TIMER_LOW, last_rd + 8'h0a, 8'hff);
    repeat (4) begin
      {usb_dplus_pin, regulator_pin, osc_input_pin, usb_dminus_pin} = 4'($random(seed));
      repeat (3) @(negedge sys_clk);
      rd_exp(ADDR_AUX_INPUT, {4'h0, usb_dplus_pin, regulator_pin, osc_input_pin,
             usb_dminus_pin}, 8'hff);
    end
    io(3'b010, ADDR_CLOCK_CONFIG, 8'h00, 8'h70);
    rd_exp(ADDR_CLOCK_CONFIG, 8'h70, 8'hff);
    io(3'b001, 8'h00, ADDR_CLOCK_CONFIG, 8'h81);
    halt_chk(LONG_C);
    chk8({7'h00, ext_osc_active}, 8'h01);
    io(3'b010, ADDR_CLOCK_CONFIG, 8'h00, 8'h80);
    chk8({6'h00, ext_osc_active, cpu_halt}, 8'h02);
    suspend_wake = 1'b1;
    @(negedge sys_clk);
    suspend_wake = 1'b0;
    halt_chk(WAKE_C);
    chk8({7'h00, ext_osc_active}, 8'h00);
    io(3'b010, ADDR_CLOCK_CONFIG, 8'h00, 8'h01);
    halt_chk(SHORT_C);
    io(3'b010, ADDR_WDOG_KICK, 8'h00, 8'h00);
    chk8({7'h00, watchdog_reset}, 8'h01);
    do_reset();
    chk8(port0_out | clock_config | {7'h00, ext_osc_active}, 8'h00);
    rd_exp(ADDR_PROC_STAT_CTL, RST_PROC_STAT_CTL, 8'hff);
    repeat (3) @(negedge sys_clk);
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
